//--- hub_irq_and_fwd_status.sv
// interrupt aggregation and synchronized forwarding status for the camera hub
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module hub_irq_and_fwd_status
  import hub_irq_pkg::*;
(
  input wire logic aclk, // register clock, 250 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [NUM_SRC-1:0] src_event, // source event pulses: rx0, rx1, tx
  input wire logic [NUM_SRC-1:0] src_clear, // source cause-register read pulses
  input wire logic engine_sync_ok, // engine able to deliver synced video
  input wire logic sync_frame_sent, // pulse: one synced frame sent
  input wire logic sync_loss_event, // pulse: synced video lost
  output sync_mode_t sync_forward_mode, // mode to the forwarding engine
  output logic irq // level interrupt to the controller
);

  reg_wr_t wr;
  reg_rd_t rd;
  logic [7:0] rd_value;
  logic rd_hit;
  logic wr_hit;

  logic global_irq_enable_r;
  logic [NUM_SRC-1:0] src_enable_r;
  logic [NUM_SRC-1:0] src_flag_r;
  logic sync_locked_status_r;
  logic sync_loss_flag_r;
  trk_state_t trk_r;
  trk_state_t trk_nxt;
  logic [NUM_EVT-1:0] evt_sts_r;
  logic [NUM_EVT-1:0] evt_en_r;
  logic [NUM_EVT-1:0] evt_in;
  logic global_irq_pending;
  logic [7:0] irq_ctl_val;
  logic [7:0] irq_sts_val;
  logic [7:0] forward_sync_status_val;

  // mapped register test, shared by read and write paths
  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    idx_mapped = (idx == IDX_FWD_CTL) || (idx == IDX_FORWARD_SYNC_STATUS) || (idx == IDX_IRQ_CTL) ||
                 (idx == IDX_IRQ_STS) || (idx == IDX_EVT_STS) || (idx == IDX_EVT_CLR) ||
                 (idx == IDX_EVT_EN);
  endfunction : idx_mapped

  axil_reg_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr(wr),
    .rd(rd),
    .rd_value(rd_value),
    .rd_hit(rd_hit),
    .wr_hit(wr_hit)
  );

  assign rd_hit = idx_mapped(rd.idx);
  assign wr_hit = idx_mapped(wr.idx);

  // forwarding mode field; reserved bits of the control byte are dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_forward_mode <= MODE_DISABLED;
    else if (wr.en && wr.idx == IDX_FWD_CTL)
      sync_forward_mode <= sync_mode_t'(wr.data[MODE_LSB +: 2]);
  end

  // interrupt enables; only bits 7, 4, 1 and 0 are writable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      global_irq_enable_r <= 1'b0;
      src_enable_r <= '0;
    end
    else if (wr.en && wr.idx == IDX_IRQ_CTL)
    begin
      global_irq_enable_r <= wr.data[GLOBAL_BIT];
      for (int i = 0; i < NUM_SRC; i++)
        src_enable_r[i] <= wr.data[SRC_BIT[i]];
    end
  end

  // sticky source flags; an event in the clearing cycle keeps the flag set
  generate
    for (genvar g = 0; g < NUM_SRC; g++)
    begin : g_src
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          src_flag_r[g] <= 1'b0;
        else if (src_event[g])
          src_flag_r[g] <= 1'b1;
        else if (src_clear[g])
          src_flag_r[g] <= 1'b0;
      end
    end
  endgenerate

  assign global_irq_pending = |(src_flag_r & src_enable_r);

  // tracker next state: armed only once a synced frame has gone out
  always_comb
  begin
    trk_nxt = trk_r;
    unique case (trk_r)
      TRK_OFF:
        if (sync_forward_mode != MODE_DISABLED)
          trk_nxt = TRK_WAIT;
      TRK_WAIT:
        if (sync_forward_mode == MODE_DISABLED)
          trk_nxt = TRK_OFF;
        else if (sync_frame_sent)
          trk_nxt = TRK_ARMED;
      TRK_ARMED:
        if (sync_forward_mode == MODE_DISABLED)
          trk_nxt = TRK_OFF;
      default:
        trk_nxt = TRK_OFF;
    endcase
  end

  // tracker state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trk_r <= TRK_OFF;
    else
      trk_r <= trk_nxt;
  end

  // locked status follows the engine, forced low while forwarding is off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_locked_status_r <= 1'b0;
    else
      sync_locked_status_r <= engine_sync_ok && (sync_forward_mode != MODE_DISABLED);
  end

  // failure flag: loss before the first synced frame is not a failure
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_loss_flag_r <= 1'b0;
    else if (sync_loss_event && trk_r == TRK_ARMED)
      sync_loss_flag_r <= 1'b1;
    else if (rd.en && rd.idx == IDX_FORWARD_SYNC_STATUS)
      sync_loss_flag_r <= 1'b0;
  end

  // lock change events for the auxiliary sticky status
  assign evt_in[EVT_LOCK_GAIN] = (trk_r != TRK_OFF) && engine_sync_ok && !sync_locked_status_r &&
                                 (sync_forward_mode != MODE_DISABLED);
  assign evt_in[EVT_LOCK_DROP] = sync_locked_status_r && !engine_sync_ok;

  // auxiliary sticky status; write-one-to-clear register, set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_sts_r <= '0;
    else if (wr.en && wr.idx == IDX_EVT_CLR)
      evt_sts_r <= (evt_sts_r & ~wr.data[NUM_EVT-1:0]) | evt_in;
    else
      evt_sts_r <= evt_sts_r | evt_in;
  end

  // auxiliary enables
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_en_r <= '0;
    else if (wr.en && wr.idx == IDX_EVT_EN)
      evt_en_r <= wr.data[NUM_EVT-1:0];
  end

  // registered interrupt; the global enable masks every cause
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= global_irq_enable_r && (global_irq_pending || |(evt_sts_r & evt_en_r));
  end

  // read views of the documented registers; reserved bits read zero
  always_comb
  begin
    irq_ctl_val = RST_BYTE;
    irq_sts_val = RST_BYTE;
    forward_sync_status_val = RST_BYTE;
    irq_ctl_val[GLOBAL_BIT] = global_irq_enable_r;
    irq_sts_val[GLOBAL_BIT] = global_irq_pending;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      irq_ctl_val[SRC_BIT[i]] = src_enable_r[i];
      irq_sts_val[SRC_BIT[i]] = src_flag_r[i];
    end
    forward_sync_status_val[LOCKED_BIT] = sync_locked_status_r;
    forward_sync_status_val[LOSS_BIT] = sync_loss_flag_r;
  end

  // read mux; status registers ignore writes, clear register reads zero
  always_comb
  begin
    rd_value = RST_BYTE;
    unique case (rd.idx)
      IDX_FWD_CTL: rd_value[MODE_LSB +: 2] = sync_forward_mode;
      IDX_FORWARD_SYNC_STATUS: rd_value = forward_sync_status_val;
      IDX_IRQ_CTL: rd_value = irq_ctl_val;
      IDX_IRQ_STS: rd_value = irq_sts_val;
      IDX_EVT_STS: rd_value[NUM_EVT-1:0] = evt_sts_r;
      IDX_EVT_EN: rd_value[NUM_EVT-1:0] = evt_en_r;
      default: rd_value = RST_BYTE;
    endcase
  end

endmodule : hub_irq_and_fwd_status

//--- hub_irq_pkg.sv
// shared constants and carrier types for the camera hub interrupt and forwarding status block
package hub_irq_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FWD_CTL = 8'h21;
  localparam logic [IDX_W-1:0] IDX_FORWARD_SYNC_STATUS = 8'h22;
  localparam logic [IDX_W-1:0] IDX_IRQ_CTL = 8'h23;
  localparam logic [IDX_W-1:0] IDX_IRQ_STS = 8'h24;
  localparam logic [IDX_W-1:0] IDX_EVT_STS = 8'h30;
  localparam logic [IDX_W-1:0] IDX_EVT_CLR = 8'h31;
  localparam logic [IDX_W-1:0] IDX_EVT_EN = 8'h32;

  // field positions in the 8-bit registers
  localparam int MODE_LSB = 2;
  localparam int LOCKED_BIT = 0;
  localparam int LOSS_BIT = 2;
  localparam int GLOBAL_BIT = 7;
  localparam int NUM_SRC = 3;
  localparam int SRC_BIT [NUM_SRC] = '{0, 1, 4};
  localparam int NUM_EVT = 2;
  localparam int EVT_LOCK_GAIN = 0;
  localparam int EVT_LOCK_DROP = 1;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // synchronized forwarding modes
  typedef enum logic [1:0] {
    MODE_DISABLED = 2'h0,
    MODE_BASIC = 2'h1,
    MODE_LINE_INTERLEAVE = 2'h2,
    MODE_LINE_CONCAT = 2'h3
  } sync_mode_t;

  // sync tracker states, gray along off -> wait -> armed
  typedef enum logic [1:0] {
    TRK_OFF = 2'h0,
    TRK_WAIT = 2'h1,
    TRK_ARMED = 2'h3
  } trk_state_t;

  // register write strobe with payload
  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] idx;
    logic [7:0] data;
  } reg_wr_t;

  // register read strobe
  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] idx;
  } reg_rd_t;

endpackage : hub_irq_pkg

//--- axil_reg_port.sv
// axi4-lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ns
module axil_reg_port
  import hub_irq_pkg::*;
(
  input wire logic aclk, // register clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [DATA_W-1:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [DATA_W-1:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output reg_wr_t wr, // write strobe to register file
  output reg_rd_t rd, // read strobe to register file
  input wire logic [7:0] rd_value, // value at rd.idx
  input wire logic rd_hit, // rd.idx is mapped
  input wire logic wr_hit // wr.idx is mapped
);

  logic [IDX_W-1:0] aw_idx_r;
  logic [7:0] w_byte_r;
  logic w_lane0_r;
  logic aw_held_r;
  logic w_held_r;

  // address and data are taken in either order, then held until both are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      aw_idx_r <= '0;
      w_byte_r <= RST_BYTE;
      w_lane0_r <= 1'b0;
    end
    else
    begin
      awready <= !aw_held_r && !(awvalid && awready) && !bvalid;
      wready <= !w_held_r && !(wvalid && wready) && !bvalid;
      if (awvalid && awready)
      begin
        aw_held_r <= 1'b1;
        aw_idx_r <= awaddr[IDX_LSB +: IDX_W];
      end
      if (wvalid && wready)
      begin
        w_held_r <= 1'b1;
        w_byte_r <= wdata[7:0];
        w_lane0_r <= wstrb[0];
      end
      if (wr.en)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
    end
  end

  // only byte lane 0 carries register bits; a write without it stores a zero byte
  assign wr.en = aw_held_r && w_held_r && !bvalid;
  assign wr.idx = aw_idx_r;
  assign wr.data = w_lane0_r ? w_byte_r : RST_BYTE;

  // write response one cycle after the write strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (wr.en)
    begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  assign rd.en = arvalid && arready;
  assign rd.idx = araddr[IDX_LSB +: IDX_W];

  // read data is sampled at the address edge, so clear-on-read acts the same edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= RD_ZERO;
      rresp <= RESP_OKAY;
    end
    else if (rd.en)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_value};
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
    else
      arready <= !rvalid;
  end

endmodule : axil_reg_port

//--- hub_irq_asserts.sv
// checker for the hub interrupt and forwarding status block
`timescale 1ns/1ns
module hub_irq_chk
  import hub_irq_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic [ADDR_W-1:0] s_axi_araddr, // rd addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [DATA_W-1:0] s_axi_rdata, // rd data
  input wire logic [1:0] s_axi_rresp, // rd resp
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_bvalid, // b valid
  input wire sync_mode_t sync_forward_mode, // mode
  input wire logic irq // interrupt
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [IDX_W-1:0] ar_idx;
  logic [IDX_W-1:0] idx_r;
  logic ar_map;
  // decode of the offered read index
  assign ar_idx = s_axi_araddr[IDX_W+IDX_LSB-1:IDX_LSB];
  assign ar_map = ar_idx inside {IDX_FWD_CTL, IDX_FORWARD_SYNC_STATUS, IDX_IRQ_CTL, IDX_IRQ_STS,
                                 IDX_EVT_STS, IDX_EVT_CLR, IDX_EVT_EN};
  // index of the read in flight, needed once rvalid shows
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      idx_r <= ar_idx;
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_off_sts;
    rd_take ##0 ar_idx == IDX_FORWARD_SYNC_STATUS && sync_forward_mode == MODE_DISABLED;
  endsequence
  a_reset_quiet: assert property (
    $rose(aresetn) |-> !irq && !s_axi_rvalid && !s_axi_bvalid && sync_forward_mode == MODE_DISABLED)
    else $error("outputs not idle after reset");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_unmapped_err: assert property (
    rd_take ##0 !ar_map |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == RD_ZERO)
    else $error("unmapped read not refused");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[DATA_W-1:8] == '0)
    else $error("upper read bits not zero");
  a_global_has_src: assert property (
    s_axi_rvalid && idx_r == IDX_IRQ_STS && s_axi_rdata[GLOBAL_BIT] |-> |s_axi_rdata[4:0])
    else $error("global pending without a source flag");
  a_lock_off_zero: assert property (
    rd_off_sts ##0 $past(sync_forward_mode) == MODE_DISABLED |=> !s_axi_rdata[LOCKED_BIT])
    else $error("locked bit set while forwarding disabled");
  a_mode_by_write: assert property ($changed(sync_forward_mode) |-> $rose(s_axi_bvalid))
    else $error("mode changed without a write");
endmodule : hub_irq_chk

bind hub_irq_and_fwd_status hub_irq_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .sync_forward_mode(sync_forward_mode), .irq(irq)
);

//--- hub_src_model.sv
// stand-in for the port logic and forwarding engine beside the hub
`timescale 1ns/1ns
module hub_src_model
  import hub_irq_pkg::*;
(
  input wire logic aclk, // clock
  output logic [NUM_SRC-1:0] src_event, // event pulses
  output logic [NUM_SRC-1:0] src_clear, // cause-read pulses
  output logic engine_sync_ok, // engine synced
  output logic sync_frame_sent, // frame pulse
  output logic sync_loss_event // loss pulse
);
  logic [7:0] p_r;
  // one byte carries every pulse line so several can fire together
  assign src_event = p_r[2:0];
  assign src_clear = p_r[5:3];
  assign sync_frame_sent = p_r[6];
  assign sync_loss_event = p_r[7];
  initial
  begin
    p_r = 8'h00;
    engine_sync_ok = 1'b0;
  end
  // pulses last exactly one cycle, as the hub expects
  task automatic pulse(input logic [7:0] m);
    @(posedge aclk);
    p_r <= m;
    @(posedge aclk);
    p_r <= 8'h00;
  endtask : pulse
  task automatic lvl(input logic v);
    @(posedge aclk);
    engine_sync_ok <= v;
  endtask : lvl
endmodule : hub_src_model

//--- testbench.sv
// self-checking bench for the hub interrupt and forwarding status block
`timescale 1ns/1ns
module testbench;
  import hub_irq_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sync_ok, frame, loss, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] wstrb;
  logic [NUM_SRC-1:0] src_event, src_clear;
  sync_mode_t mode;
  int miscompares = 0;
  int comparisons = 0;
  hub_src_model src (.aclk(aclk), .src_event(src_event), .src_clear(src_clear),
    .engine_sync_ok(sync_ok), .sync_frame_sent(frame), .sync_loss_event(loss));
  hub_irq_and_fwd_status dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src_event(src_event), .src_clear(src_clear), .engine_sync_ok(sync_ok),
    .sync_frame_sent(frame), .sync_loss_event(loss), .sync_forward_mode(mode), .irq(irq)
  );
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic end_sim;
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // a wait that ran out ends the run at once
  task automatic tmo(input int n);
    if (n >= 64)
    begin
      chk("timeout", 32'h0, 32'h1);
      end_sim();
    end
  endtask : tmo
  // address and data offered together, each dropped when taken
  // bready stays high after the answer so back-to-back calls never drive it twice in one step
  task automatic wx(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    rsp = bresp;
    tmo(n);
  endtask : wx
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    wx({2'b00, idx, 2'b00}, d, 4'hF);
  endtask : wr
  // rready likewise stays high between reads
  task automatic rx(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    d = rdata;
    rsp = rresp;
    tmo(n);
  endtask : rx
  task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] d);
    rx({2'b00, idx, 2'b00}, d);
  endtask : rd
  task automatic rc(input string nm, input logic [IDX_W-1:0] idx, input logic [7:0] e);
    logic [31:0] d;
    rd(idx, d);
    chk(nm, {24'h000000, e}, d);
  endtask : rc
  // irq is registered, so let two edges pass before looking
  task automatic ci(input string nm, input logic e);
    repeat (2) @(posedge aclk);
    chk(nm, {31'h0, e}, {31'h0, irq});
  endtask : ci
  // reset values, read-only places and an unmapped index
  task automatic t_reset;
    logic [31:0] d;
    rc("fwd_ctl", IDX_FWD_CTL, 8'h00);
    rc("forward_sync_status", IDX_FORWARD_SYNC_STATUS, 8'h00);
    rc("irq_ctl", IDX_IRQ_CTL, 8'h00);
    rc("irq_sts", IDX_IRQ_STS, 8'h00);
    wr(IDX_IRQ_STS, 8'hFF);
    wr(IDX_FORWARD_SYNC_STATUS, 8'hFF);
    rc("sts_ro", IDX_IRQ_STS, 8'h00);
    rc("fwd_ro", IDX_FORWARD_SYNC_STATUS, 8'h00);
    wr(IDX_IRQ_CTL, 8'hFF);
    rc("ctl_bits", IDX_IRQ_CTL, 8'h93);
    // a write without byte lane 0 stores a zero byte
    wx({2'b00, IDX_IRQ_CTL, 2'b00}, 8'hFF, 4'h0);
    rc("no_lane0", IDX_IRQ_CTL, 8'h00);
    rd(8'h7F, d);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    // every address line high: refused both ways, nothing stored
    wx(12'hFFF, 8'hFF, 4'hF);
    chk("unmapped_wr", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rx(12'hFFF, d);
    chk("unmapped_rd", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rc("ctl_kept", IDX_IRQ_CTL, 8'h00);
  endtask : t_reset
  // one enable at a time while all three sources fire
  task automatic t_sources;
    logic [7:0] b;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      b = 8'h01 << SRC_BIT[i];
      wr(IDX_IRQ_CTL, 8'h80 | b);
      src.pulse(8'h07);
      ci("irq_on", 1'b1);
      rc("pending", IDX_IRQ_STS, 8'h93);
      src.pulse(8'h08 << i);
      ci("irq_off", 1'b0);
      rc("others", IDX_IRQ_STS, 8'h13 & ~b);
      src.pulse(8'h38);
      rc("all_clr", IDX_IRQ_STS, 8'h00);
    end
  endtask : t_sources
  // pending shows while the output is masked
  task automatic t_masked;
    wr(IDX_IRQ_CTL, 8'h13);
    src.pulse(8'h04);
    ci("irq_mask", 1'b0);
    rc("global", IDX_IRQ_STS, 8'h90);
    wr(IDX_IRQ_CTL, 8'h93);
    ci("irq_late", 1'b1);
    src.pulse(8'h20);
    ci("irq_gone", 1'b0);
    wr(IDX_IRQ_CTL, 8'h00);
  endtask : t_masked
  // modes, lock status and the clear-on-read failure flag
  task automatic t_sync;
    src.lvl(1'b1);
    src.pulse(8'hC0);
    rc("off", IDX_FORWARD_SYNC_STATUS, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      wr(IDX_FWD_CTL, 8'(m << MODE_LSB));
      rc("mode_reg", IDX_FWD_CTL, 8'(m << MODE_LSB));
      chk("mode", m, {30'h0, mode});
    end
    rc("locked", IDX_FORWARD_SYNC_STATUS, 8'h01);
    src.pulse(8'h80);
    rc("no_frame", IDX_FORWARD_SYNC_STATUS, 8'h01);
    src.pulse(8'h40);
    src.pulse(8'h80);
    repeat (4) @(posedge aclk);
    rc("fail", IDX_FORWARD_SYNC_STATUS, 8'h05);
    rc("fail_clr", IDX_FORWARD_SYNC_STATUS, 8'h01);
    src.lvl(1'b0);
    // locked bit lags the engine by one edge, so let it settle before the read
    @(posedge aclk);
    rc("unlocked", IDX_FORWARD_SYNC_STATUS, 8'h00);
    src.lvl(1'b1);
    wr(IDX_FWD_CTL, 8'h00);
    rc("off_again", IDX_FORWARD_SYNC_STATUS, 8'h00);
    // the drop and the regain above left both lock events sticky
    rc("aux_sts", IDX_EVT_STS, 8'h03);
    wr(IDX_EVT_EN, 8'h03);
    wr(IDX_IRQ_CTL, 8'h80);
    ci("aux_irq", 1'b1);
    wr(IDX_EVT_CLR, 8'h03);
    ci("aux_clr", 1'b0);
    rc("aux_none", IDX_EVT_STS, 8'h00);
  endtask : t_sync
  initial
  begin
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_sources();
    t_masked();
    t_sync();
    end_sim();
  end
endmodule : testbench
